//--- hw/dac_load_consts.svh
// Purpose: constants for the channel input staging and load block
// Assumes: byte-addressed register port, 16-bit registers take two bytes
// Notes:   16-bit registers use the low address of each pair
// Function
// - select register 0xE8, reset 0xFF, bit per channel
// - broadcast write copies value to selected channels
// - deselected channels keep their staged value
// - trigger register 0xE9, bit 7 loads enabled channels
// - writing zero to trigger does nothing
// - eight 16-bit input registers 0xEA..0xF8, reset zero
// - input write never changes dac register
// - dac register updates only on load events
// - broadcast data register 0xE6 reads last write
`ifndef DAC_LOAD_CONSTS_SVH
`define DAC_LOAD_CONSTS_SVH
`define ADDR_BCAST_DATA   8'he6
`define ADDR_BCAST_SEL    8'he8
`define ADDR_SOFT_TRIG    8'he9
`define ADDR_CH_BASE      8'hea
`define ADDR_CH_LAST      8'hf8
`define CH_STEP           2
`define RST_BCAST_SEL     8'hff
`define RST_SOFT_TRIG     8'h00
`define RST_CH_VALUE      16'h0000
`define TRIG_BIT          7
`define NUM_CH            8
`endif

//--- hw/dac_load_pkg.sv
// Purpose: shared types for the staging and load block
// Assumes: eight channels of 16 bits
// Notes:   constants live in dac_load_consts.svh
package dac_load_pkg;
  typedef logic [15:0] ch_value_t;
  typedef logic [7:0]  ch_mask_t;
endpackage : dac_load_pkg

//--- hw/channel_stage.sv
// Purpose: one channel's input register and dac register
// Assumes: write strobes are single-cycle, same clock
// Notes:   load has no effect on the input register
`timescale 1ns/1ps
`include "dac_load_consts.svh"
module channel_stage
  import dac_load_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      stage_we,
  input  wire ch_value_t stage_data,
  input  wire logic      load,
  output ch_value_t      input_q,
  output ch_value_t      dac_q
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      input_q <= `RST_CH_VALUE;
    end else if (stage_we) begin
      input_q <= stage_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_q <= `RST_CH_VALUE;
    end else if (load) begin
      dac_q <= input_q;
    end
  end
endmodule : channel_stage

//--- hw/dac_input_broadcast_and_load.sv
// Purpose: broadcast staging and software/hardware load of eight dac channels
// Assumes: reg_addr/reg_wr/reg_rd/reg_wdata come from the serial host logic on clk
// Notes:   load_strobe is a pin and is synchronised; enable mask is an input
`timescale 1ns/1ps
`include "dac_load_consts.svh"
module dac_input_broadcast_and_load
  import dac_load_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata_r,
  output logic             reg_ack_r,
  input  wire logic        load_strobe,
  input  wire ch_mask_t    soft_load_channel_enable,
  output ch_value_t        channel_dac_reg_r [`NUM_CH],
  output logic             soft_load_trigger_r
);
  ch_value_t bcast_data_r;
  ch_mask_t  bcast_sel_r;
  ch_value_t ch_input [`NUM_CH];
  ch_value_t ch_dac [`NUM_CH];
  logic [1:0] strobe_sync_r;
  logic       strobe_prev_r;
  logic       hw_load;
  logic       bcast_wr;

  // index of a channel input register, or -1 when not one
  function automatic int ch_index(input logic [7:0] a);
    int k;
    k = -1;
    for (int i = 0; i < `NUM_CH; i++) begin
      if (a == 8'(`ADDR_CH_BASE + `CH_STEP * i)) k = i;
    end
    return k;
  endfunction : ch_index

  // load pin crosses in through two flops; rising edge loads
  // limitation: a pin held high through reset gives one load just after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_sync_r <= 2'h0;
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_sync_r <= {strobe_sync_r[0], load_strobe};
      strobe_prev_r <= strobe_sync_r[1];
    end
  end
  assign hw_load  = strobe_sync_r[1] & ~strobe_prev_r;
  assign bcast_wr = reg_wr && (reg_addr == `ADDR_BCAST_DATA);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcast_data_r <= `RST_CH_VALUE;
    end else if (bcast_wr) begin
      bcast_data_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bcast_sel_r <= `RST_BCAST_SEL;
    end else if (reg_wr && reg_addr == `ADDR_BCAST_SEL) begin
      bcast_sel_r <= reg_wdata[7:0];
    end
  end

  // trigger pulses only on a one
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      soft_load_trigger_r <= 1'b0;
    end else begin
      soft_load_trigger_r <= reg_wr && reg_addr == `ADDR_SOFT_TRIG && reg_wdata[`TRIG_BIT];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++) begin : g_ch
      logic we;
      logic ld;
      ch_value_t wd;
      // broadcast fans out by mask; direct and broadcast writes both stage reg_wdata
      assign we = (reg_wr && ch_index(reg_addr) == g) || (bcast_wr && bcast_sel_r[g]);
      assign wd = reg_wdata;
      // load on either event, if enabled for software
      assign ld = hw_load || (soft_load_trigger_r && soft_load_channel_enable[g]);
      channel_stage u_stage (
        .clk        (clk),
        .rst_b      (rst_b),
        .stage_we   (we),
        .stage_data (wd),
        .load       (ld),
        .input_q    (ch_input[g]),
        .dac_q      (ch_dac[g])
      );
      assign channel_dac_reg_r[g] = ch_dac[g];
    end
  endgenerate

  // ack follows writes as well, so the host can pace every access the same way
  // read port: one cycle after the request; unmapped reads zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 16'h0000;
      reg_ack_r   <= 1'b0;
    end else begin
      reg_ack_r   <= reg_rd || reg_wr;
      reg_rdata_r <= 16'h0000;
      if (reg_rd) begin
        if (reg_addr == `ADDR_BCAST_DATA) reg_rdata_r <= bcast_data_r;
        else if (reg_addr == `ADDR_BCAST_SEL) reg_rdata_r <= {8'h00, bcast_sel_r};
        else if (ch_index(reg_addr) >= 0) reg_rdata_r <= ch_input[ch_index(reg_addr)];
      end
    end
  end

  property p_sel_reset;
    @(posedge clk) $rose(rst_b) |-> bcast_sel_r == `RST_BCAST_SEL;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("select mask reset wrong");

  // per-channel checks; one copy of each property for every channel
  genvar h;
  generate
    for (h = 0; h < `NUM_CH; h++) begin : g_chk
      property p_bcast_copy;
        @(posedge clk) disable iff (!rst_b)
          bcast_wr && bcast_sel_r[h] |=> ch_input[h] == $past(reg_wdata);
      endproperty
      a_bcast_copy: assert property (p_bcast_copy) else $error("broadcast copy missed");

      property p_bcast_keep;
        @(posedge clk) disable iff (!rst_b)
          bcast_wr && !bcast_sel_r[h] |=> $stable(ch_input[h]);
      endproperty
      a_bcast_keep: assert property (p_bcast_keep) else $error("deselected channel changed");

      property p_ch_write;
        @(posedge clk) disable iff (!rst_b)
          reg_wr && ch_index(reg_addr) == h |=> ch_input[h] == $past(reg_wdata);
      endproperty
      a_ch_write: assert property (p_ch_write) else $error("direct input write missed");

      // first edge after release still shows the reset values
      property p_ch_reset;
        @(posedge clk) $rose(rst_b) |-> ch_input[h] == `RST_CH_VALUE && ch_dac[h] == `RST_CH_VALUE;
      endproperty
      a_ch_reset: assert property (p_ch_reset) else $error("channel reset value wrong");

      property p_no_load_hold;
        @(posedge clk) disable iff (!rst_b)
          !hw_load && !(soft_load_trigger_r && soft_load_channel_enable[h]) |=> $stable(ch_dac[h]);
      endproperty
      a_no_load_hold: assert property (p_no_load_hold) else $error("dac changed without load");

      property p_load_copy;
        @(posedge clk) disable iff (!rst_b)
          hw_load |=> ch_dac[h] == $past(ch_input[h]);
      endproperty
      a_load_copy: assert property (p_load_copy) else $error("load did not copy");

      property p_soft_copy;
        @(posedge clk) disable iff (!rst_b)
          soft_load_trigger_r && soft_load_channel_enable[h] |=> ch_dac[h] == $past(ch_input[h]);
      endproperty
      a_soft_copy: assert property (p_soft_copy) else $error("software load did not copy");
    end
  endgenerate

  property p_trig;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ADDR_SOFT_TRIG && reg_wdata[`TRIG_BIT] |=> soft_load_trigger_r;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not raised");

  property p_trig_zero;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ADDR_SOFT_TRIG && !reg_wdata[`TRIG_BIT] |=> !soft_load_trigger_r;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("zero write triggered");

  property p_trig_read;
    @(posedge clk) disable iff (!rst_b)
      reg_rd && reg_addr == `ADDR_SOFT_TRIG |=> reg_rdata_r == {8'h00, `RST_SOFT_TRIG};
  endproperty
  a_trig_read: assert property (p_trig_read) else $error("trigger register read not zero");

  property p_sel_write;
    @(posedge clk) disable iff (!rst_b)
      reg_wr && reg_addr == `ADDR_BCAST_SEL |=> bcast_sel_r == $past(reg_wdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("select mask write missed");

  property p_bcast_store;
    @(posedge clk) disable iff (!rst_b)
      bcast_wr |=> bcast_data_r == $past(reg_wdata);
  endproperty
  a_bcast_store: assert property (p_bcast_store) else $error("broadcast data not stored");

  property p_bcast_read;
    @(posedge clk) disable iff (!rst_b)
      bcast_wr ##1 !bcast_wr ##1 (reg_rd && reg_addr == `ADDR_BCAST_DATA) |=> reg_rdata_r == $past(reg_wdata, 3);
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast readback wrong");

  property p_pulse;
    @(posedge clk) disable iff (!rst_b)
      soft_load_trigger_r && !(reg_wr && reg_addr == `ADDR_SOFT_TRIG) |=> !soft_load_trigger_r;
  endproperty
  a_pulse: assert property (p_pulse) else $error("trigger stuck");

  c_bcast: cover property (@(posedge clk) disable iff (!rst_b) bcast_wr && bcast_sel_r != 8'h00);
  c_soft:  cover property (@(posedge clk) disable iff (!rst_b) soft_load_trigger_r);
  c_hw:    cover property (@(posedge clk) disable iff (!rst_b) hw_load);
  c_none:  cover property (@(posedge clk) disable iff (!rst_b) bcast_wr && bcast_sel_r == 8'h00);
endmodule : dac_input_broadcast_and_load

//--- testbench/dac_input_broadcast_and_load_tb.sv
// Purpose: self-checking bench for the broadcast staging and load block
// Assumes: strobes driven on the falling edge, answers sampled one edge later
// Notes:   expected input and dac values come from a small model kept here
`timescale 1ns/1ps
`include "dac_load_consts.svh"
module dac_input_broadcast_and_load_tb
  import dac_load_pkg::*;
();
  logic        clk         = 1'b0;
  logic        rst_b       = 1'b0;
  logic [7:0]  reg_addr    = 8'h00;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [15:0] reg_wdata   = 16'h0000;
  logic        load_strobe = 1'b0;
  ch_mask_t    soft_load_channel_enable = 8'h00;
  logic [15:0] reg_rdata_r;
  logic        reg_ack_r;
  logic        soft_load_trigger_r;
  ch_value_t   channel_dac_reg_r [`NUM_CH];
  ch_value_t   exp_in [`NUM_CH];
  ch_value_t   exp_dac [`NUM_CH];
  ch_mask_t    sel_m;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          npulse;
  // rows: address, write data, expected read back (0x10 is unmapped)
  logic [7:0]  t_addr [6] = '{8'he8, 8'he9, 8'hea, 8'hf8, 8'he6, 8'h10};
  logic [15:0] t_data [6] = '{16'h00a5, 16'h007f, 16'h1234, 16'habcd, 16'h0f0f, 16'h5555};
  logic [15:0] t_exp  [6] = '{16'h00a5, 16'h0000, 16'h1234, 16'habcd, 16'h0f0f, 16'h0000};

  always #2.5 clk = ~clk;

  dac_input_broadcast_and_load u_dut (
    .clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r, .reg_ack_r,
    .load_strobe, .soft_load_channel_enable, .channel_dac_reg_r, .soft_load_trigger_r
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    if (a == `ADDR_BCAST_SEL) sel_m = d[7:0];
    for (int i = 0; i < `NUM_CH; i++)
      if ((a == `ADDR_BCAST_DATA && sel_m[i]) || a == 8'(`ADDR_CH_BASE + 2 * i)) exp_in[i] = d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata_r, e);
    chk({15'h0000, reg_ack_r}, 16'h0001);
  endtask : rd

  task automatic ins_all;
    for (int i = 0; i < `NUM_CH; i++) rd(8'(`ADDR_CH_BASE + 2 * i), exp_in[i]);
  endtask : ins_all

  task automatic dacs_all;
    for (int i = 0; i < `NUM_CH; i++) chk(channel_dac_reg_r[i], exp_dac[i]);
  endtask : dacs_all

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    sel_m = `RST_BCAST_SEL;
    for (int i = 0; i < `NUM_CH; i++) begin
      exp_in[i] = '0;
      exp_dac[i] = '0;
    end
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    rd(`ADDR_BCAST_SEL, 16'h00ff);
    for (int r = 0; r < 6; r++) begin
      wr(t_addr[r], t_data[r]);
      rd(t_addr[r], t_exp[r]);
    end
    $display("test table done");
    ins_all();
    dacs_all();
    wr(`ADDR_BCAST_SEL, 16'h0000);
    wr(`ADDR_BCAST_DATA, 16'h7777);
    rd(`ADDR_BCAST_DATA, 16'h7777);
    ins_all();
    $display("test broadcast done");
    // enable only some channels so a load of the others would show
    soft_load_channel_enable = 8'h3c;
    for (int v = 0; v < 2; v++) begin
      wr(`ADDR_SOFT_TRIG, v ? 16'h0080 : 16'h0000);
      npulse = 0;
      repeat (4) begin
        npulse += int'(soft_load_trigger_r === 1'b1);
        @(negedge clk);
      end
      chk(16'(npulse), 16'(v));
      for (int i = 0; i < `NUM_CH; i++) if (v == 1 && soft_load_channel_enable[i]) exp_dac[i] = exp_in[i];
      dacs_all();
    end
    wr(8'hec, 16'h2222);
    dacs_all();
    rd(`ADDR_SOFT_TRIG, 16'h0000);
    $display("test soft load done");
    // pin load reaches every channel after the synchroniser
    load_strobe = 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < `NUM_CH; i++) exp_dac[i] = exp_in[i];
    dacs_all();
    load_strobe = 1'b0;
    $display("test pin load done");
    rst_b = 1'b0;
    @(negedge clk);
    rst_b = 1'b1;
    sel_m = `RST_BCAST_SEL;
    for (int i = 0; i < `NUM_CH; i++) begin
      exp_in[i] = '0;
      exp_dac[i] = '0;
    end
    dacs_all();
    rd(`ADDR_BCAST_SEL, 16'h00ff);
    ins_all();
    $display("test reset done");
    summarize();
  end

  // hang guard
  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end
endmodule : dac_input_broadcast_and_load_tb
